// >>> verilog/ssd_cfg.svh
// constants for the dual-port burst sram core: widths, lane and nibble fields, latencies
// assumes one 10 MHz ref_clk; all ddr edges arrive as one-cycle enables
`ifndef SSD_CFG_SVH
`define SSD_CFG_SVH

// data word width of the 18-bit configuration
`define SSD_DW        18
// address bits needed by the 18-bit configuration
`define SSD_AW        19
// beat index width: four words per burst
`define SSD_BW        2
// last beat of a burst
`define SSD_LAST_BEAT 2'h3
// first beat of a burst
`define SSD_FIRST_BEAT 2'h0
// lane 0 covers bits 8..0, lane 1 covers bits 17..9
`define SSD_LANE0_HI  8
`define SSD_LANE0_LO  0
`define SSD_LANE1_HI  17
`define SSD_LANE1_LO  9
// narrow configuration: nibble 0 bits 3..0, nibble 1 bits 7..4
`define SSD_NIB0_HI   3
`define SSD_NIB0_LO   0
`define SSD_NIB1_HI   7
`define SSD_NIB1_LO   4
// read latency in output clock edges after the select edge
`define SSD_LAT_PLL   2'h3
`define SSD_LAT_BYP   2'h2
// highest clock rate of the bypass mode, in MHz (the 10 MHz core is far below it)
`define SSD_BYP_FMAX_MHZ 167

`endif

// >>> verilog/ssd_pkg.sv
// types of the dual-port burst sram core: write phase enum and the state record
// assumes ssd_cfg.svh is on the include path
`include "ssd_cfg.svh"

package ssd_pkg;

    // write burst phase, gray coded along idle, arm, beat1, beat2, beat3
    typedef enum logic [2:0] {
        SSD_WR_IDLE = 3'h0,
        SSD_WR_ARM  = 3'h1,
        SSD_WR_B1   = 3'h3,
        SSD_WR_B2   = 3'h2,
        SSD_WR_B3   = 3'h6
    } ssd_wr_ph_t;

    // whole control state of the core
    typedef struct packed {
        ssd_wr_ph_t           wr_ph;        // write burst phase
        logic [`SSD_AW-1:0]   wr_addr;      // address of the running write burst
        logic                 wr_late;      // write address still to come on the bus
        logic                 pend;         // a second write waits for the running one
        logic [`SSD_AW-1:0]   pend_addr;    // its address
        logic                 pend_late;    // its address still to come
        logic                 rd_wait;      // read accepted, latency running
        logic [1:0]           rd_cnt;       // output edges seen since acceptance
        logic [`SSD_AW-1:0]   rd_wait_addr; // address of the waiting read
        logic                 rd_act;       // read burst being driven
        logic [`SSD_BW-1:0]   rd_beat;      // next beat to drive
        logic [`SSD_AW-1:0]   rd_addr;      // address of the driven burst
        logic [`SSD_DW-1:0]   q;            // read data pins
        logic                 q_oe;         // read data pin drive enable
    } ssd_state_t;

endpackage : ssd_pkg

// >>> verilog/ssd_core.sv
// dual-port burst sram core, 18-bit configuration with optional narrow nibble mode
// assumes every ddr clock edge arrives as a one-cycle enable synchronous to ref_clk
`timescale 1ns/1ps
`include "ssd_cfg.svh"

module ssd_core (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                k_rise,             // rising edge of positive input clock
    input  wire logic                kn_rise,            // rising edge of negative input clock
    input  wire logic                c_rise,             // rising edge of positive output clock
    input  wire logic                cn_rise,            // rising edge of negative output clock
    input  wire logic                single_clock_mode,  // output data timed by the input pair
    input  wire logic                pll_bypass_n,       // low selects the one-cycle latency mode
    input  wire logic                nibble_mode,        // narrow configuration with nibble selects
    input  wire logic                read_port_sel_n,
    input  wire logic                write_port_sel_n,
    input  wire logic [`SSD_AW-1:0]  addr,
    input  wire logic [`SSD_DW-1:0]  wdata,
    input  wire logic [1:0]          lane_write_sel_n,
    input  wire logic [1:0]          nibble_write_sel_n,
    output logic      [`SSD_DW-1:0]  q,
    output logic                     q_oe
);

    localparam int WA = `SSD_AW + `SSD_BW;       // word address width

    ssd_pkg::ssd_state_t state_reg;              // registered state
    ssd_pkg::ssd_state_t state_next;             // next state

    // one array, with the beat index in the low address bits
    logic [`SSD_DW-1:0]  mem [0:(1<<WA)-1];

    logic                mem_we;                 // store a write beat this cycle
    logic [WA-1:0]       mem_wa;                 // word address of the beat
    logic [`SSD_DW-1:0]  mem_mask;               // bits of the beat to store
    logic                pos_out;                // positive output edge
    logic                neg_out;                // negative output edge
    logic [1:0]          rd_lat;                 // read latency in output edges

    // outputs straight from the state flops
    assign q    = state_reg.q;
    assign q_oe = state_reg.q_oe;

    // next-state logic for both ports
    always_comb begin
        logic [`SSD_AW-1:0] wa;                  // address of the current write beat
        logic [`SSD_BW-1:0] wbeat;               // index of the current write beat
        logic               wstart;              // a write burst becomes armed
        state_next = state_reg;
        mem_we     = 1'b0;
        mem_mask   = '0;
        wa         = state_reg.wr_addr;
        wbeat      = `SSD_FIRST_BEAT;
        wstart     = 1'b0;

        // output edges come from C or, in single clock mode, from K
        pos_out = single_clock_mode ? k_rise : c_rise;
        neg_out = single_clock_mode ? kn_rise : cn_rise;
        rd_lat  = pll_bypass_n ? `SSD_LAT_PLL : `SSD_LAT_BYP;

        // ---------------- write port ----------------
        unique case (state_reg.wr_ph)
            ssd_pkg::SSD_WR_IDLE: begin
                // nothing to store
            end
            ssd_pkg::SSD_WR_ARM: begin
                // beat 0 waits for the K rise after the select edge
                if (k_rise) begin
                    mem_we = 1'b1;
                    if (state_reg.wr_late) begin
                        wa = addr;
                    end
                    state_next.wr_addr = wa;
                    state_next.wr_late = 1'b0;
                    state_next.wr_ph   = ssd_pkg::SSD_WR_B1;
                end
            end
            ssd_pkg::SSD_WR_B1: begin
                // beat 1 on the following negative edge
                if (kn_rise) begin
                    mem_we           = 1'b1;
                    wbeat            = 2'h1;
                    state_next.wr_ph = ssd_pkg::SSD_WR_B2;
                end
            end
            ssd_pkg::SSD_WR_B2: begin
                // beat 2 on the next positive edge
                if (k_rise) begin
                    mem_we           = 1'b1;
                    wbeat            = 2'h2;
                    state_next.wr_ph = ssd_pkg::SSD_WR_B3;
                end
            end
            ssd_pkg::SSD_WR_B3: begin
                // last beat; a waiting write takes over
                if (kn_rise) begin
                    mem_we = 1'b1;
                    wbeat  = `SSD_LAST_BEAT;
                    if (state_reg.pend) begin
                        state_next.wr_ph   = ssd_pkg::SSD_WR_ARM;
                        state_next.wr_addr = state_reg.pend_addr;
                        state_next.wr_late = state_reg.pend_late;
                        state_next.pend    = 1'b0;
                    end else begin
                        state_next.wr_ph = ssd_pkg::SSD_WR_IDLE;
                    end
                end
            end
            default: begin
                // illegal code: return to idle
                state_next.wr_ph = ssd_pkg::SSD_WR_IDLE;
            end
        endcase

        // byte lanes of the beat that are stored
        if (nibble_mode) begin
            if (!nibble_write_sel_n[0]) mem_mask[`SSD_NIB0_HI:`SSD_NIB0_LO] = '1;
            if (!nibble_write_sel_n[1]) mem_mask[`SSD_NIB1_HI:`SSD_NIB1_LO] = '1;
        end else begin
            if (!lane_write_sel_n[0]) mem_mask[`SSD_LANE0_HI:`SSD_LANE0_LO] = '1;
            if (!lane_write_sel_n[1]) mem_mask[`SSD_LANE1_HI:`SSD_LANE1_LO] = '1;
        end
        mem_wa = {wa, wbeat};

        // write select sampled on K; deselected port ignores the address
        if (k_rise && !write_port_sel_n) begin
            // both selects on one edge: the write address follows on the next K
            wstart = (state_reg.wr_ph == ssd_pkg::SSD_WR_IDLE);
            if (wstart) begin
                state_next.wr_ph   = ssd_pkg::SSD_WR_ARM;
                state_next.wr_addr = addr;
                state_next.wr_late = !read_port_sel_n;
            end else begin
                state_next.pend      = 1'b1;
                state_next.pend_addr = addr;
                state_next.pend_late = !read_port_sel_n;
            end
        end

        // ---------------- read port ----------------
        if (pos_out || neg_out) begin
            if (state_reg.rd_wait && (state_reg.rd_cnt + 2'h1 == rd_lat)) begin
                // latency done: drive beat 0 of the waiting burst
                state_next.q       = mem[{state_reg.rd_wait_addr, `SSD_FIRST_BEAT}];
                state_next.q_oe    = 1'b1;
                state_next.rd_wait = 1'b0;
                state_next.rd_act  = 1'b1;
                state_next.rd_addr = state_reg.rd_wait_addr;
                state_next.rd_beat = 2'h1;
            end else begin
                if (state_reg.rd_wait) begin
                    state_next.rd_cnt = state_reg.rd_cnt + 2'h1;
                end
                if (state_reg.rd_act) begin
                    // drive the next sequential word of the burst
                    state_next.q       = mem[{state_reg.rd_addr, state_reg.rd_beat}];
                    state_next.q_oe    = 1'b1;
                    state_next.rd_beat = state_reg.rd_beat + 2'h1;
                    if (state_reg.rd_beat == `SSD_LAST_BEAT) begin
                        state_next.rd_act = 1'b0;
                    end
                end else if (pos_out) begin
                    // idle at a positive output edge: release the pins
                    state_next.q_oe = 1'b0;
                end
            end
        end

        // read select sampled on K; a deselected port ignores the address
        if (k_rise && !read_port_sel_n) begin
            state_next.rd_wait      = 1'b1;
            state_next.rd_cnt       = 2'h0;
            state_next.rd_wait_addr = addr;
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // array store with lane mask; unselected bits keep their contents
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= (mem[mem_wa] & ~mem_mask) | (wdata & mem_mask);
        end
    end

endmodule : ssd_core

// >>> testbench/ssd_core_checker.sv
// checker for the burst sram core: read output timing, burst length, floating
// assumes the edge enables arrive as one-cycle pulses on ref_clk
`timescale 1ns/1ps
`include "ssd_cfg.svh"
module ssd_core_checker (
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    input wire logic               k_rise,
    input wire logic               kn_rise,
    input wire logic               c_rise,
    input wire logic               cn_rise,
    input wire logic               single_clock_mode,
    input wire logic               pll_bypass_n,
    input wire logic               read_port_sel_n,
    input wire logic [`SSD_DW-1:0] q,
    input wire logic               q_oe
);
    logic       out_edge; // any output clock edge
    logic       pos_edge; // positive output clock edge
    logic [7:0] beat_cnt; // output edges seen while driving
    logic [7:0] gap_cnt;  // output edges since the last read select
    assign out_edge = single_clock_mode ? (k_rise | kn_rise) : (c_rise | cn_rise);
    assign pos_edge = single_clock_mode ? k_rise : c_rise;
    // edge counters; gap saturates so an idle port never wraps back
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            beat_cnt <= 8'h0;
            gap_cnt  <= 8'hff;
        end else begin
            beat_cnt <= q_oe ? beat_cnt + {7'h0, out_edge} : 8'h0;
            gap_cnt  <= (k_rise && !read_port_sel_n) ? 8'h0 : gap_cnt + {7'h0, out_edge && gap_cnt != 8'hff};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence rd_take_s;
        k_rise && !read_port_sel_n;
    endsequence
    sequence burst_hold_s;
        q_oe [*4];
    endsequence
    rst_quiet_a: assert property ($fell(sys_rst) |-> !q_oe && !(|q))
        else $error("outputs active right after reset");
    rd_answer_a: assert property (rd_take_s |-> ##[1:12] q_oe)
        else $error("read select gave no data");
    oe_edge_a: assert property ($rose(q_oe) |-> $past(out_edge))
        else $error("drive started off an output edge");
    q_edge_a: assert property (q_oe && $changed(q) |-> $past(out_edge))
        else $error("read data moved off an output edge");
    float_drop_a: assert property ($fell(q_oe) |-> $past(pos_edge))
        else $error("float not on a positive output edge");
    // the float waits for a positive edge, so odd latency leaves one idle negative edge in the count
    burst_four_a: assert property ($fell(q_oe) |-> beat_cnt[1:0] == {1'b0, pll_bypass_n} && beat_cnt > 8'h3)
        else $error("burst length not a multiple of four");
    burst_hold_a: assert property ($rose(q_oe) |-> burst_hold_s)
        else $error("burst cut short");
    idle_float_a: assert property (gap_cnt >= 8'ha |-> !q_oe)
        else $error("read data driven with port deselected");
endmodule : ssd_core_checker
bind ssd_core ssd_core_checker i_ssd_core_checker (.ref_clk, .sys_rst, .k_rise, .kn_rise, .c_rise,
    .cn_rise, .single_clock_mode, .pll_bypass_n, .read_port_sel_n, .q, .q_oe);

// >>> testbench/ssd_ctl_model.sv
// controller-side clock model: alternating k and kn edge enables, output pair in phase
// assumes ref_clk runs free; the bench drives selects, address and data
`timescale 1ns/1ps
module ssd_ctl_model (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    output logic      k_rise,
    output logic      kn_rise,
    output logic      c_rise,
    output logic      cn_rise
);
    // k and kn alternate every cycle and never coincide
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            k_rise  <= 1'b0;
            kn_rise <= 1'b1;
        end else begin
            k_rise  <= ~k_rise;
            kn_rise <= k_rise;
        end
    end
    assign c_rise  = k_rise;
    assign cn_rise = kn_rise;
endmodule : ssd_ctl_model

// >>> testbench/sync_sram_dual_port_ddr_pins_bench.sv
// bench for the burst sram core: lane and nibble writes, reads in both latency modes
// assumes the controller model supplies alternating k and kn edge enables
`timescale 1ns/1ps
`include "ssd_cfg.svh"
module sync_sram_dual_port_ddr_pins_bench;
    logic ref_clk = 1'b0, sys_rst = 1'b1, single_clock_mode = 1'b0, pll_bypass_n = 1'b1, nibble_mode = 1'b0;
    logic read_port_sel_n = 1'b1, write_port_sel_n = 1'b1, k_rise, kn_rise, c_rise, cn_rise, q_oe;
    logic [1:0] lane_write_sel_n = 2'h3, nibble_write_sel_n = 2'h3;
    logic [`SSD_AW-1:0] addr = 19'h0;
    logic [`SSD_DW-1:0] wdata = 18'h0, q;
    logic [`SSD_DW-1:0] mdl [logic [`SSD_AW+1:0]]; // expected word per address and beat
    int fails = 0, checked = 0, cycles = 0;
    always #50 ref_clk = ~ref_clk;
    ssd_ctl_model i_ssd_ctl_model (.ref_clk, .sys_rst, .k_rise, .kn_rise, .c_rise, .cn_rise);
    ssd_core i_ssd_core (.ref_clk, .sys_rst, .k_rise, .kn_rise, .c_rise, .cn_rise, .single_clock_mode,
        .pll_bypass_n, .nibble_mode, .read_port_sel_n, .write_port_sel_n, .addr, .wdata,
        .lane_write_sel_n, .nibble_write_sel_n, .q, .q_oe);
    task automatic give_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails = fails + 1;
            give_verdict();
        end
    end
    task automatic check(input logic [`SSD_DW-1:0] seen, input logic [`SSD_DW-1:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // land on the edge whose next cycle samples k
    task automatic to_k();
        do @(negedge ref_clk); while (kn_rise !== 1'b1);
        @(posedge ref_clk);
    endtask : to_k
    // write burst, s holds two active-low selects per beat; the idle selects get the inverted field
    // late: a read of ra shares the select edge and the write address follows on the beat-0 k
    task automatic wr(input logic [`SSD_AW-1:0] a, input logic [71:0] d, input logic [7:0] s,
                      input logic late, input logic [`SSD_AW-1:0] ra);
        logic [`SSD_DW-1:0] w;
        to_k();
        write_port_sel_n <= 1'b0;
        read_port_sel_n <= ~late;
        addr <= late ? ra : a;
        @(posedge ref_clk);
        write_port_sel_n <= 1'b1;
        read_port_sel_n <= 1'b1;
        addr <= late ? a : ~a;
        for (int b = 0; b < 4; b++) begin
            @(posedge ref_clk);
            if (b == 1) addr <= ~a;
            wdata <= d[b*18 +: 18];
            lane_write_sel_n <= nibble_mode ? ~s[b*2 +: 2] : s[b*2 +: 2];
            nibble_write_sel_n <= nibble_mode ? s[b*2 +: 2] : ~s[b*2 +: 2];
            w = mdl[{a, 2'(b)}];
            for (int i = 0; i < 18; i++)
                if (nibble_mode ? (i < 8 && !s[b*2 + i/4]) : !s[b*2 + int'(i > 8)]) w[i] = d[b*18 + i];
            mdl[{a, 2'(b)}] = w;
        end
        @(posedge ref_clk);
        wdata <= ~wdata;
        lane_write_sel_n <= 2'h0;
        nibble_write_sel_n <= 2'h0;
    endtask : wr
    // read burst with lat output edges before the first beat
    task automatic rd(input logic [`SSD_AW-1:0] a, input int lat);
        to_k();
        read_port_sel_n <= 1'b0;
        addr <= a;
        @(posedge ref_clk);
        read_port_sel_n <= 1'b1;
        addr <= ~a;
        repeat (lat - 1) @(posedge ref_clk);
        @(negedge ref_clk);
        check(`SSD_DW'(q_oe), 18'h0);
        @(posedge ref_clk);
        for (int b = 0; b < 4; b++) begin
            @(negedge ref_clk);
            check(q, mdl[{a, 2'(b)}]);
            check(`SSD_DW'(q_oe), 18'h1);
            @(posedge ref_clk);
        end
        repeat (lat - 2) @(posedge ref_clk);
        @(negedge ref_clk);
        check(`SSD_DW'(q_oe), 18'h0);
    endtask : rd
    task automatic t_plain();
        wr(19'h7ffff, {18'h2b3c4, 18'h1d2e3, 18'h0f1a2, 18'h31415}, 8'h00, 1'b0, 19'h0);
        rd(19'h7ffff, 3);
    endtask : t_plain
    task automatic t_lanes();
        wr(19'h7ffff, {18'h0aaaa, 18'h15555, 18'h3c3c3, 18'h24924}, 8'b11_00_10_01, 1'b0, 19'h0);
        rd(19'h7ffff, 3);
    endtask : t_lanes
    task automatic t_nibble();
        @(posedge ref_clk);
        nibble_mode <= 1'b1;
        wr(19'h7ffff, {18'h3ffff, 18'h12345, 18'h2f0f0, 18'h0abcd}, 8'b00_11_01_10, 1'b0, 19'h0);
        nibble_mode <= 1'b0;
        rd(19'h7ffff, 3);
    endtask : t_nibble
    // read and write selected on one k edge; the later bypass read of 7ffff proves ra was not written
    task automatic t_both();
        wr(19'h00001, {18'h1e1e1, 18'h2d2d2, 18'h3c3c3, 18'h04b4b}, 8'h00, 1'b1, 19'h7ffff);
        rd(19'h00001, 3);
    endtask : t_both
    task automatic t_bypass();
        @(posedge ref_clk);
        pll_bypass_n <= 1'b0;
        single_clock_mode <= 1'b1;
        rd(19'h7ffff, 2);
    endtask : t_bypass
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        check(`SSD_DW'(q_oe), 18'h0);
        t_plain();
        t_lanes();
        t_nibble();
        t_both();
        t_bypass();
        give_verdict();
    end
endmodule : sync_sram_dual_port_ddr_pins_bench
